// >>> rtl/sxd_cfg.svh
// sxd_cfg.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name from the channel module and the bench
`ifndef SXD_CFG_SVH
`define SXD_CFG_SVH
// ***********************
// register offsets
// ***********************
`define SXD_CTRL_OFS    8'h00
`define SXD_CFG_OFS     8'h04
`define SXD_MULT_OFS    8'h08
`define SXD_STAT_OFS    8'h0C
// ***********************
// fields and reset values
// ***********************
`define SXD_STAT_PLL    0
`define SXD_STAT_CDR    1
`define SXD_STAT_ALIGN  2
`define SXD_STAT_FCNT   8
`define SXD_STAT_CHAN   16
`define SXD_CTRL_RST    5'h04
`define SXD_CFG_RST     10'h000
`define SXD_MULT_RST    5'h0A
`define SXD_MULT_MIN    5'h04
`define SXD_MULT_MAX    5'h19
// ***********************
// timing
// ***********************
`define SXD_CLK_MHZ     100
`define SXD_PLL_LOCK_NS 1000
`define SXD_CDR_TRANS   5'h10
`define SXD_MAX_RUN     7'h40
`define SXD_ALIGN_GOOD  3'h4
`endif

// >>> rtl/sxd_pkg.sv
// sxd_pkg: types and width helpers of the serial channel
// assumes: nothing beyond the constants header
package sxd_pkg;
   typedef enum logic [1:0] {
      ENC_NONE   = 2'b00,
      ENC_8B10B  = 2'b01,
      ENC_64B66B = 2'b10,
      ENC_64B67B = 2'b11
   } sxd_enc_t;
   typedef struct packed {
      sxd_enc_t   rx_enc;
      sxd_enc_t   tx_enc;
      logic [2:0] rx_wsel;
      logic [2:0] tx_wsel;
   } sxd_cfg_t;
   typedef struct packed {
      logic rx_rst;
      logic tx_rst;
      logic fifo_en;
      logic rx_en;
      logic tx_en;
   } sxd_ctrl_t;
   typedef enum logic [1:0] {
      AL_HUNT   = 2'b00,
      AL_CHECK  = 2'b01,
      AL_LOCKED = 2'b10
   } sxd_align_t;
   function automatic logic [7:0] sxd_wbits(input logic [2:0] s);
      logic [7:0] w;
      w = 8'h10;
      unique case (s)
         3'h0: w = 8'h10;
         3'h1: w = 8'h14;
         3'h2: w = 8'h20;
         3'h3: w = 8'h28;
         3'h4: w = 8'h40;
         3'h5: w = 8'h50;
         3'h6: w = 8'h80;
         3'h7: w = 8'hA0;
      endcase
      return w;
   endfunction : sxd_wbits
   function automatic logic [7:0] sxd_flen(input logic [7:0] w, input sxd_enc_t e);
      logic [7:0] l;
      l = w;
      unique case (e)
         ENC_NONE:   l = w;
         ENC_8B10B:  l = w + (w >> 2);
         ENC_64B66B: l = w + 8'h02;
         ENC_64B67B: l = w + 8'h03;
      endcase
      return l;
   endfunction : sxd_flen
endpackage : sxd_pkg

// >>> rtl/sxd_channel.sv
// sxd_channel: one serial transceiver channel datapath with ahb-lite registers
// assumes: one clock; serial bits move one per enabled clock; inputs synchronous
//
// Behaviour
// - serializer ratios 16,20,32,40,64,80 selectable
// - high-rate variant adds 128 and 160
// - divided word clock output for tx data
// - tx fifo enabled or bypassed by config
// - line encoding 8b10b, 64b66b, 64b67b or none
// - deserializer widths match, 128/160 high-rate only
// - bit clock recovered from data stream
// - nrz link, same encoding both ends
// - rx words handed on user clock
// - bit clock multiplier 4 to 25
// - tx and rx run independently
// - all settable, subset live-changeable
// - channels grouped by four
`include "sxd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sxd_channel #(
   parameter bit         HIGH_RATE  = 1'b1,
   parameter int         FIFO_DEPTH = 4,
   parameter logic [1:0] CHANNEL_ID = 2'h0
) (
   // clock, reset, enable
   input  wire logic         REF_CLK,
   input  wire logic         RST,
   input  wire logic         CE,
   // ahb-lite slave
   input  wire logic         HSEL,
   input  wire logic [31:0]  HADDR,
   input  wire logic [1:0]   HTRANS,
   input  wire logic         HWRITE,
   input  wire logic [2:0]   HSIZE,
   input  wire logic [31:0]  HWDATA,
   input  wire logic         HREADY,
   output var  logic [31:0]  HRDATA,
   output var  logic         HREADYOUT,
   output var  logic         HRESP,
   // transmit side
   input  wire logic [159:0] TX_DATA,
   input  wire logic         TX_VALID,
   output var  logic         TX_READY,
   output var  logic         TX_PAR_CLK,
   output var  logic         TX_SERIAL,
   // receive side
   input  wire logic         RX_SERIAL,
   input  wire logic         RX_USR_CLK,
   output var  logic [159:0] RX_DATA,
   output var  logic         RX_VALID
);
   localparam int DW = 160;
   localparam int FW = 200;
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int PLL_LOCK_CYC = (`SXD_PLL_LOCK_NS * `SXD_CLK_MHZ + 999) / 1000;

   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (RST || !CE);

   // ***********************
   // register bus
   // ***********************
   sxd_pkg::sxd_ctrl_t ctrl_q;
   sxd_pkg::sxd_cfg_t  cfg_q;
   logic [4:0]         mult_q;
   logic               dp_wr_q;
   logic [7:0]         dp_addr_q;
   logic [31:0]        rdata_q;
   logic               pll_lock_q;
   logic               cdr_lock_q;
   logic               aligned;
   logic [CW-1:0]      fcnt_q;

   wire         ap_take = HSEL & HTRANS[1] & HREADY;
   wire         wr_ctrl = dp_wr_q & (dp_addr_q == `SXD_CTRL_OFS);
   wire         wr_cfg  = dp_wr_q & (dp_addr_q == `SXD_CFG_OFS);
   wire         wr_mult = dp_wr_q & (dp_addr_q == `SXD_MULT_OFS);
   wire [31:0]  stat_w  = (32'(CHANNEL_ID) << `SXD_STAT_CHAN)
                        | (32'(fcnt_q) << `SXD_STAT_FCNT)
                        | (32'(aligned) << `SXD_STAT_ALIGN)
                        | (32'(cdr_lock_q) << `SXD_STAT_CDR)
                        | (32'(pll_lock_q) << `SXD_STAT_PLL);
   wire [7:0]   ra      = HADDR[7:0];
   wire [31:0]  rd_mux  = (ra == `SXD_CTRL_OFS) ? 32'(ctrl_q) :
                          (ra == `SXD_CFG_OFS)  ? 32'(cfg_q)  :
                          (ra == `SXD_MULT_OFS) ? 32'(mult_q) :
                          (ra == `SXD_STAT_OFS) ? stat_w      : 32'h0000_0000;
   // wide words refused on the mid-rate variant: the old selection stays
   wire [2:0]   new_txw = (!HIGH_RATE && HWDATA[2]   && HWDATA[1]) ? cfg_q.tx_wsel : HWDATA[2:0];
   wire [2:0]   new_rxw = (!HIGH_RATE && HWDATA[5]   && HWDATA[4]) ? cfg_q.rx_wsel : HWDATA[5:3];
   sxd_pkg::sxd_cfg_t cfg_d;
   assign cfg_d = wr_cfg ? {HWDATA[9:6], new_rxw, new_txw} : cfg_q;
   wire         tx_chg  = (cfg_d.tx_wsel != cfg_q.tx_wsel) || (cfg_d.tx_enc != cfg_q.tx_enc);
   wire         rx_chg  = (cfg_d.rx_wsel != cfg_q.rx_wsel) || (cfg_d.rx_enc != cfg_q.rx_enc);
   // multiplier only while both directions are stopped, and only in range
   wire         mult_ok = wr_mult & ~ctrl_q.tx_en & ~ctrl_q.rx_en
                        & (HWDATA[4:0] >= `SXD_MULT_MIN) & (HWDATA[4:0] <= `SXD_MULT_MAX)
                        & (HWDATA[31:5] == 27'h0);

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
         rdata_q   <= 32'h0000_0000;
         ctrl_q    <= `SXD_CTRL_RST;
         cfg_q     <= `SXD_CFG_RST;
         mult_q    <= `SXD_MULT_RST;
      end else if (CE) begin
         dp_wr_q   <= ap_take & HWRITE;
         dp_addr_q <= HADDR[7:0];
         rdata_q   <= (ap_take & ~HWRITE) ? rd_mux : rdata_q;
         cfg_q     <= cfg_d;
         if (wr_ctrl) ctrl_q <= HWDATA[4:0];
         if (mult_ok) mult_q <= HWDATA[4:0];
      end
   end
   assign HRDATA    = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   // ***********************
   // bit clock synthesis
   // ***********************
   logic [15:0] pll_cnt_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pll_cnt_q  <= 16'h0000;
         pll_lock_q <= 1'b0;
      end else if (CE) begin
         if (mult_ok) begin
            pll_cnt_q  <= 16'h0000;
            pll_lock_q <= 1'b0;
         end else if (pll_cnt_q == 16'(PLL_LOCK_CYC - 1)) begin
            pll_lock_q <= 1'b1;
         end else begin
            pll_cnt_q  <= pll_cnt_q + 16'h0001;
         end
      end
   end

   // ***********************
   // transmit fifo
   // ***********************
   logic [DW-1:0] fifo_mem [FIFO_DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic          rdy_q;
   logic [7:0]    tx_left_q;
   logic [FW-1:0] tx_sh_q;
   logic          ser_q;
   logic          pclk_q;

   wire           tx_act  = ctrl_q.tx_en & ~ctrl_q.tx_rst & pll_lock_q;
   wire [7:0]     tx_w    = sxd_pkg::sxd_wbits(cfg_q.tx_wsel);
   wire [7:0]     tx_len  = sxd_pkg::sxd_flen(tx_w, cfg_q.tx_enc);
   wire           tx_load = tx_act & (tx_left_q == 8'h00);
   // bypass keeps a single holding word so timing to the serializer is unchanged
   wire [CW-1:0]  lim     = ctrl_q.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
   // ready follows next cycle's limit, so a bypass switch cannot leave it high on a full stage
   wire           fen_d   = wr_ctrl ? HWDATA[2] : ctrl_q.fifo_en;
   wire [CW-1:0]  lim_d   = fen_d ? CW'(FIFO_DEPTH) : CW'(1);
   wire           push    = TX_VALID & rdy_q;
   wire           pop     = tx_load & (fcnt_q != '0);
   wire           flush   = tx_chg | ~tx_act;
   wire [CW-1:0]  fcnt_d  = flush ? '0 : CW'(fcnt_q + CW'(push) - CW'(pop));
   wire [AW-1:0]  wp_inc  = (wp_q == AW'(FIFO_DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
   wire [AW-1:0]  rp_inc  = (rp_q == AW'(FIFO_DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);

   always_ff @(posedge REF_CLK) begin
      if (CE && push) fifo_mem[wp_q] <= TX_DATA;
   end
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wp_q   <= '0;
         rp_q   <= '0;
         fcnt_q <= '0;
         rdy_q  <= 1'b0;
      end else if (CE) begin
         wp_q   <= flush ? '0 : (push ? wp_inc : wp_q);
         rp_q   <= flush ? '0 : (pop ? rp_inc : rp_q);
         fcnt_q <= fcnt_d;
         rdy_q  <= ~flush & (fcnt_d < lim_d);
      end
   end
   assign TX_READY = rdy_q;

   // ***********************
   // encoder and serializer
   // ***********************
   wire [DW-1:0] tx_mask = (DW'(1) << tx_w) - DW'(1);
   // an empty fifo sends an encoded zero word to keep the line running
   wire [DW-1:0] tx_word = pop ? (fifo_mem[rp_q] & tx_mask) : '0;
   logic [FW-1:0] tx_frame;
   always_comb begin
      tx_frame = '0;
      unique case (cfg_q.tx_enc)
         sxd_pkg::ENC_NONE:   tx_frame = FW'(tx_word);
         sxd_pkg::ENC_8B10B: begin
            for (int k = 0; k < DW / 8; k++) begin
               tx_frame[10*k +: 8] = tx_word[8*k +: 8];
               tx_frame[10*k + 8]  = ~tx_word[8*k + 7];
               tx_frame[10*k + 9]  = tx_word[8*k + 7];
            end
         end
         sxd_pkg::ENC_64B66B: tx_frame = {tx_word, 2'b01} & FW'({(DW+2){1'b1}});
         sxd_pkg::ENC_64B67B: tx_frame = {tx_word, 3'b101} & FW'({(DW+3){1'b1}});
      endcase
   end
   wire [7:0] tx_left_d = ~tx_act ? 8'h00 : (tx_load ? (tx_len - 8'h01) : (tx_left_q - 8'h01));

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         tx_left_q <= 8'h00;
         tx_sh_q   <= '0;
         ser_q     <= 1'b0;
         pclk_q    <= 1'b0;
      end else if (CE) begin
         tx_left_q <= tx_chg ? 8'h00 : tx_left_d;
         if (tx_load) begin
            ser_q   <= tx_frame[0];
            tx_sh_q <= tx_frame >> 1;
         end else if (tx_act) begin
            ser_q   <= tx_sh_q[0];
            tx_sh_q <= tx_sh_q >> 1;
         end
         pclk_q    <= tx_act & (tx_left_d >= (tx_len >> 1));
      end
   end
   assign TX_SERIAL  = ser_q;
   assign TX_PAR_CLK = pclk_q;

   // ***********************
   // clock recovery
   // ***********************
   logic       prev_q;
   logic [6:0] run_q;
   logic [4:0] trans_q;
   wire        rx_act = ctrl_q.rx_en & ~ctrl_q.rx_rst & pll_lock_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         prev_q     <= 1'b0;
         run_q      <= 7'h00;
         trans_q    <= 5'h00;
         cdr_lock_q <= 1'b0;
      end else if (CE) begin
         prev_q <= RX_SERIAL;
         if (!rx_act) begin
            run_q      <= 7'h00;
            trans_q    <= 5'h00;
            cdr_lock_q <= 1'b0;
         end else if (RX_SERIAL != prev_q) begin
            run_q   <= 7'h00;
            trans_q <= (trans_q == `SXD_CDR_TRANS) ? trans_q : trans_q + 5'h01;
            if (trans_q == `SXD_CDR_TRANS - 5'h01) cdr_lock_q <= 1'b1;
         end else if (run_q == `SXD_MAX_RUN) begin
            trans_q    <= 5'h00; // too few transitions: recovery lost
            cdr_lock_q <= 1'b0;
         end else begin
            run_q <= run_q + 7'h01;
         end
      end
   end

   // ***********************
   // deserializer and alignment
   // ***********************
   sxd_pkg::sxd_align_t st_q;
   logic [FW-1:0] sr_q;
   logic [7:0]    rcnt_q;
   logic          slip_q;
   logic [2:0]    good_q;
   wire [7:0]     rx_w    = sxd_pkg::sxd_wbits(cfg_q.rx_wsel);
   wire [7:0]     rx_len  = sxd_pkg::sxd_flen(rx_w, cfg_q.rx_enc);
   wire [7:0]     rx_tgt  = slip_q ? rx_len : rx_len - 8'h01; // one spare bit slips
   wire           rx_run  = rx_act & cdr_lock_q;
   wire           rx_done = rx_run & (rcnt_q == rx_tgt);
   wire [FW-1:0]  sr_n    = {RX_SERIAL, sr_q[FW-1:1]};
   wire [FW-1:0]  rx_fr   = sr_n >> (8'(FW) - rx_len);
   wire [DW-1:0]  rx_mask = (DW'(1) << rx_w) - DW'(1);
   logic [DW-1:0] rx_word;
   logic          rx_good;
   always_comb begin
      rx_word = '0;
      rx_good = 1'b1;
      unique case (cfg_q.rx_enc)
         sxd_pkg::ENC_NONE:   rx_word = rx_fr[DW-1:0];
         sxd_pkg::ENC_8B10B: begin
            for (int k = 0; k < DW / 8; k++) begin
               rx_word[8*k +: 8] = rx_fr[10*k +: 8];
               if (8'(k) < (rx_w >> 3) && (rx_fr[10*k+8] == rx_fr[10*k+9]
                   || rx_fr[10*k+9] != rx_fr[10*k+7])) rx_good = 1'b0;
            end
         end
         sxd_pkg::ENC_64B66B: begin
            rx_word = rx_fr[DW+1:2];
            rx_good = (rx_fr[1:0] == 2'b01);
         end
         sxd_pkg::ENC_64B67B: begin
            rx_word = rx_fr[DW+2:3];
            rx_good = (rx_fr[2:0] == 3'b101);
         end
      endcase
   end
   assign aligned = (cfg_q.rx_enc == sxd_pkg::ENC_NONE) | (st_q == sxd_pkg::AL_LOCKED);
   wire rx_clr = rx_chg | ~rx_run;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_q   <= sxd_pkg::AL_HUNT;
         sr_q   <= '0;
         rcnt_q <= 8'h00;
         slip_q <= 1'b0;
         good_q <= 3'h0;
      end else if (CE) begin
         if (rx_run) sr_q <= sr_n;
         rcnt_q <= (rx_clr || rx_done) ? 8'h00 : rcnt_q + 8'h01;
         if (rx_clr) begin
            st_q   <= sxd_pkg::AL_HUNT;
            slip_q <= 1'b0;
            good_q <= 3'h0;
         end else if (rx_done) begin
            slip_q <= ~rx_good;
            good_q <= rx_good ? good_q + 3'h1 : 3'h0;
            unique case (st_q)
               sxd_pkg::AL_HUNT:   st_q <= rx_good ? sxd_pkg::AL_CHECK : sxd_pkg::AL_HUNT;
               sxd_pkg::AL_CHECK:  st_q <= !rx_good ? sxd_pkg::AL_HUNT :
                                           (good_q == `SXD_ALIGN_GOOD - 3'h1)
                                           ? sxd_pkg::AL_LOCKED : sxd_pkg::AL_CHECK;
               sxd_pkg::AL_LOCKED: st_q <= rx_good ? sxd_pkg::AL_LOCKED : sxd_pkg::AL_HUNT;
               default:            st_q <= sxd_pkg::AL_HUNT;
            endcase
         end
      end
   end

   // ***********************
   // user-clock hand-over
   // ***********************
   logic [DW-1:0] pend_q;
   logic          pend_v_q;
   logic          usr_prev_q;
   logic [DW-1:0] rxd_q;
   logic          rxv_q;
   wire           word_ok  = rx_done & cdr_lock_q & aligned;
   wire           usr_edge = RX_USR_CLK & ~usr_prev_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pend_q     <= '0;
         pend_v_q   <= 1'b0;
         usr_prev_q <= 1'b0;
         rxd_q      <= '0;
         rxv_q      <= 1'b0;
      end else if (CE) begin
         usr_prev_q <= RX_USR_CLK;
         if (word_ok) pend_q <= rx_word & rx_mask;
         // a new word in the edge cycle is kept: set beats clear
         pend_v_q   <= word_ok | (pend_v_q & ~usr_edge & ~rx_clr);
         rxv_q      <= usr_edge & pend_v_q;
         if (usr_edge && pend_v_q) rxd_q <= pend_q;
      end
   end
   assign RX_DATA  = rxd_q;
   assign RX_VALID = rxv_q;

   // ***********************
   // checks
   // ***********************
   tx_wide_a: assert property (!HIGH_RATE |-> cfg_q.tx_wsel < 3'h6)
      else $error("wide tx word on mid-rate");
   rx_wide_a: assert property (!HIGH_RATE |-> cfg_q.rx_wsel < 3'h6)
      else $error("wide rx word on mid-rate");
   mult_range_a: assert property (mult_q >= `SXD_MULT_MIN && mult_q <= `SXD_MULT_MAX)
      else $error("multiplier out of range");
   word_clk_a: assert property (tx_load && !tx_chg ##1 tx_act && !tx_chg |-> TX_PAR_CLK
                                ##1 (tx_left_q == tx_len - 8'h02))
      else $error("word clock not high at frame start");
   fifo_full_a: assert property (fcnt_q >= lim |-> !TX_READY)
      else $error("ready while fifo full");
   hdr_first_a: assert property (tx_load && !tx_chg && cfg_q.tx_enc == sxd_pkg::ENC_64B66B
                                 ##1 tx_act |-> TX_SERIAL ##1 !TX_SERIAL)
      else $error("sync header not sent first");
   flush_cfg_a: assert property (tx_chg |=> fcnt_q == '0 && !TX_READY)
      else $error("tx fifo not flushed on change");
   cdr_pll_a: assert property (cdr_lock_q |-> pll_lock_q && $past(rx_act))
      else $error("recovery locked without pll");
   valid_gate_a: assert property ($rose(pend_v_q) |-> $past(cdr_lock_q && aligned))
      else $error("word valid before lock");
   usr_hand_a: assert property (RX_VALID |-> $past(usr_edge) && $past(pend_v_q))
      else $error("rx word off user clock");
endmodule : sxd_channel
`default_nettype wire

// >>> verif/sxd_tb_pkg.sv
// sxd_tb_pkg: frame layout helpers for the bench and the remote model
// assumes: widths in bits 16..160, encoding codes as in the channel package
package sxd_tb_pkg;
   function automatic int sxd_tb_len(input int w, input logic [1:0] enc);
      case (enc)
         2'h1:    return w + w / 4;
         2'h2:    return w + 2;
         2'h3:    return w + 3;
         default: return w;
      endcase
   endfunction : sxd_tb_len
   // frame bits go out lsb first, so headers sit in the low bits
   function automatic logic [199:0] sxd_tb_frame(input logic [159:0] word, input int w,
                                                 input logic [1:0] enc);
      logic [199:0] f;
      logic [159:0] m;
      m = word & ((160'h1 << w) - 160'h1);
      f = '0;
      case (enc)
         2'h1: for (int i = 0; i < w / 8; i++) begin
            f[10*i +: 8] = m[8*i +: 8];
            f[10*i + 8]  = ~m[8*i + 7];
            f[10*i + 9]  = m[8*i + 7];
         end
         2'h2:    f[161:0] = {m, 2'h1};
         2'h3:    f[162:0] = {m, 3'h5};
         default: f[159:0] = m;
      endcase
      return f;
   endfunction : sxd_tb_frame
endpackage : sxd_tb_pkg

// >>> verif/sxd_remote.sv
// sxd_remote: far transceiver sending one repeated encoded word, one bit a clock
// assumes: shares the bit clock of the channel; no clock travels on the link
`timescale 1ns/1ps
`default_nettype none
module sxd_remote (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // stream setup
   input  wire logic         on,
   input  wire logic [1:0]   enc,
   input  wire logic [7:0]   w,
   input  wire logic [159:0] word,
   // link
   output var  logic         serial
);
   logic [199:0] frame;
   int           len;
   int           pos_q;
   assign frame = sxd_tb_pkg::sxd_tb_frame(word, int'(w), enc);
   assign len   = sxd_tb_pkg::sxd_tb_len(int'(w), enc);
   // idle toggles: transitions without any valid header alignment
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial <= 1'b0;
         pos_q  <= 0;
      end else if (!on) begin
         serial <= ~serial;
         pos_q  <= 0;
      end else begin
         serial <= frame[pos_q];
         pos_q  <= (pos_q + 1 == len) ? 0 : pos_q + 1;
      end
   end
endmodule : sxd_remote
`default_nettype wire

// >>> verif/test_serial_transceiver_datapath.sv
// test_serial_transceiver_datapath: self-checking bench of one channel
// assumes: channel registers at bus offsets of the constants header
`include "sxd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_serial_transceiver_datapath;
   typedef struct {logic [2:0] wsel; logic [1:0] enc; logic [7:0] w; logic fifo;} sxd_row_t;
   localparam logic [159:0] PAT = 160'h5678_9ABC_DEF0_1357_9BDF_2468_ACE0_3C3C_0FF0_0FF0;
   localparam logic [31:0] MW[5] = '{32'h3, 32'h1A, 32'h24, 32'h19, 32'h4};
   localparam logic [31:0] ME[5] = '{32'hA, 32'hA, 32'hA, 32'h19, 32'h4};
   sxd_row_t rows[11] = '{'{3'h0, 2'h0, 8'h10, 1'b1}, '{3'h1, 2'h0, 8'h14, 1'b0},
      '{3'h2, 2'h0, 8'h20, 1'b1}, '{3'h3, 2'h0, 8'h28, 1'b1}, '{3'h4, 2'h0, 8'h40, 1'b0},
      '{3'h5, 2'h0, 8'h50, 1'b1}, '{3'h6, 2'h0, 8'h80, 1'b1}, '{3'h7, 2'h0, 8'hA0, 1'b1},
      '{3'h2, 2'h1, 8'h20, 1'b1}, '{3'h2, 2'h2, 8'h20, 1'b0}, '{3'h2, 2'h3, 8'h20, 1'b1}};
   logic         REF_CLK = 1'b0, RST = 1'b1, CE = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic         TX_VALID = 1'b0, rm_on = 1'b0;
   logic [31:0]  HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
   logic [1:0]   HTRANS = 2'h0;
   logic [2:0]   HSIZE = 3'h2, usr_cnt = 3'h0;
   logic [159:0] TX_DATA = '0, RX_DATA;
   logic         HREADYOUT, HRESP, TX_READY, TX_PAR_CLK, TX_SERIAL, RX_SERIAL, RX_VALID;
   wire logic    RX_USR_CLK;
   int           fail_count = 0, check_count = 0;
   always #5 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) usr_cnt <= usr_cnt + 3'h1;
   assign RX_USR_CLK = usr_cnt[2];
   sxd_channel #(.HIGH_RATE(1'b1), .FIFO_DEPTH(4), .CHANNEL_ID(2'h2)) sxd_channel_inst (
      .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
      .TX_READY(TX_READY), .TX_PAR_CLK(TX_PAR_CLK), .TX_SERIAL(TX_SERIAL),
      .RX_SERIAL(RX_SERIAL), .RX_USR_CLK(RX_USR_CLK), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID));
   sxd_remote sxd_remote_inst (.clk(REF_CLK), .rst(RST), .on(rm_on), .enc(2'h3), .w(8'h20),
      .word(PAT), .serial(RX_SERIAL));
   // ***********************
   // tasks
   // ***********************
   task automatic tally_and_finish;
      if (fail_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic hang(input string msg);
      chk(1'b0, msg);
      tally_and_finish();
   endtask : hang
   task automatic wait_rdy;
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge REF_CLK);
         if (HREADYOUT === 1'b1) break;
      end
      if (n == 20) hang("bus stall");
   endtask : wait_rdy
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      HSEL <= 1'b1;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      HTRANS <= 2'h2;
      wait_rdy();
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      wait_rdy();
      q = HRDATA;
   endtask : ahb
   // valid stays up on return so back-to-back words need no gap
   task automatic tx_send(input logic [159:0] word);
      int n;
      TX_DATA <= word;
      TX_VALID <= 1'b1;
      for (n = 0; n < 400; n++) begin
         @(negedge REF_CLK);
         if (TX_READY === 1'b1) break;
      end
      if (n == 400) hang("tx never ready");
      @(posedge REF_CLK);
   endtask : tx_send
   task automatic cap_frame(input int len, output logic [199:0] f);
      int n;
      logic prev;
      f = '0;
      prev = TX_PAR_CLK;
      for (n = 0; n < 400; n++) begin
         @(negedge REF_CLK);
         if (TX_PAR_CLK === 1'b1 && prev === 1'b0) break;
         prev = TX_PAR_CLK;
      end
      if (n == 400) hang("no word clock");
      f[0] = TX_SERIAL;
      for (n = 1; n < len; n++) begin
         @(negedge REF_CLK);
         f[n] = TX_SERIAL;
      end
   endtask : cap_frame
   // ***********************
   // main sequence
   // ***********************
   initial begin
      logic [31:0] q;
      logic [199:0] f;
      logic [159:0] word;
      logic found;
      int i, k, len;
      repeat (6) @(posedge REF_CLK);
      RST <= 1'b0;
      chk({HRDATA, HREADYOUT, HRESP, TX_READY, RX_VALID} === {32'h0, 1'h1, 3'h0}, "reset");
      @(posedge REF_CLK);
      ahb(1'b0, `SXD_CTRL_OFS, 32'h0, q);
      chk(q === 32'h4, "ctrl reset value");
      ahb(1'b0, `SXD_CFG_OFS, 32'h0, q);
      chk(q === 32'h0, "cfg reset value");
      ahb(1'b0, `SXD_STAT_OFS, 32'h0, q);
      chk(q[0] === 1'b0 && q[17:16] === 2'h2, "status after reset");
      ahb(1'b1, 8'h10, 32'hFFFF_FFFF, q);
      ahb(1'b0, 8'h10, 32'h0, q);
      chk(q === 32'h0, "unmapped read");
      ahb(1'b0, `SXD_MULT_OFS, 32'h0, q);
      chk(q === 32'hA, "mult reset value");
      for (k = 0; k < 5; k++) begin
         ahb(1'b1, `SXD_MULT_OFS, MW[k], q);
         ahb(1'b0, `SXD_MULT_OFS, 32'h0, q);
         chk(q === ME[k], "mult range");
      end
      for (i = 0; i < 100; i++) begin
         ahb(1'b0, `SXD_STAT_OFS, 32'h0, q);
         if (q[0] === 1'b1) break;
      end
      chk(q[0] === 1'b1, "bit clock lock");
      ahb(1'b1, `SXD_CTRL_OFS, 32'h5, q);
      ahb(1'b1, `SXD_MULT_OFS, 32'h8, q);
      ahb(1'b0, `SXD_MULT_OFS, 32'h0, q);
      chk(q === 32'h4, "mult changed while running");
      for (i = 0; i < 11; i++) begin
         ahb(1'b1, `SXD_CTRL_OFS, {29'h0, rows[i].fifo, 2'h1}, q);
         ahb(1'b1, `SXD_CFG_OFS, {24'h0, rows[i].enc, 3'h0, rows[i].wsel}, q);
         word = PAT >> i;
         len = sxd_tb_pkg::sxd_tb_len(int'(rows[i].w), rows[i].enc);
         tx_send(word);
         TX_VALID <= 1'b0;
         found = 1'b0;
         for (k = 0; k < 4; k++) begin
            cap_frame(len, f);
            if (f === sxd_tb_pkg::sxd_tb_frame(word, int'(rows[i].w), rows[i].enc)) found = 1'b1;
         end
         chk(found, "tx frame");
         @(posedge REF_CLK);
      end
      // long frames keep words queued long enough to see the flush
      ahb(1'b1, `SXD_CFG_OFS, 32'h7, q);
      tx_send(PAT);
      tx_send(~PAT);
      tx_send(PAT);
      TX_VALID <= 1'b0;
      ahb(1'b0, `SXD_STAT_OFS, 32'h0, q);
      chk(q[15:8] === 8'h03, "fifo holds words");
      ahb(1'b1, `SXD_CFG_OFS, 32'h6, q);
      ahb(1'b0, `SXD_STAT_OFS, 32'h0, q);
      chk(q[15:8] === 8'h0, "fifo flushed on width change");
      ahb(1'b1, `SXD_CTRL_OFS, 32'h7, q);
      ahb(1'b1, `SXD_CFG_OFS, 32'h316, q);
      found = 1'b0;
      for (i = 0; i < 300; i++) begin
         @(negedge REF_CLK);
         found = found | (RX_VALID !== 1'b0);
      end
      chk(!found, "word before alignment");
      @(posedge REF_CLK);
      rm_on <= 1'b1;
      for (i = 0; i < 3000; i++) begin
         @(negedge REF_CLK);
         if (RX_VALID === 1'b1) break;
      end
      if (i == 3000) hang("no rx word");
      chk(RX_DATA === {128'h0, PAT[31:0]}, "rx word");
      @(negedge REF_CLK);
      chk(RX_VALID === 1'b0, "rx valid pulse");
      @(posedge REF_CLK);
      ahb(1'b0, `SXD_STAT_OFS, 32'h0, q);
      chk(q[2:1] === 2'h3, "recovery and alignment");
      tally_and_finish();
   end
endmodule : test_serial_transceiver_datapath
`default_nettype wire
